// File: dv/rtcs_pulse_src.sv
// Behavioural minute pulse source that drives one digital input of the block.
module rtcs_pulse_src (
    // Control from the bench.
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic [15:0] len_in,
    // Driven input line.
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    // A fire request starts one high pulse of len_in cycles; the line rests low between pulses.
    always @(posedge clk_in) begin
        if (fire_in) left <= int'(len_in);
        else if (left > 0) left <= left - 1;
    end
    assign line_out = (left > 0);
endmodule

// File: dv/rtcs_top_tb.sv
// Self-checking bench: register accesses over AXI4-Lite and pulses on the sync input.
module rtcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] CS [6] = '{6'h0A, 6'h1D, 6'h1E, 6'h03, 6'h02, 6'h39};
    logic clk_in = 1'h0;
    logic rstn_in = 1'h0;
    logic [31:0] opto_tb = 32'h0;
    logic [31:0] opto;
    logic [7:0] awaddr_in = 8'h0;
    logic [7:0] araddr_in = 8'h0;
    logic awvalid_in = 1'h0;
    logic wvalid_in = 1'h0;
    logic bready_in = 1'h0;
    logic arvalid_in = 1'h0;
    logic rready_in = 1'h0;
    logic [31:0] wdata_in = 32'h0;
    logic [3:0] wstrb_in = 4'hF;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, irq_out, event_out;
    logic [1:0] bresp_out, rresp_out, rs;
    logic [31:0] rdata_out, rv;
    logic [5:0] sec_out, min_out;
    logic [4:0] hr_out;
    logic fire = 1'h0;
    logic [15:0] plen = 16'h0;
    logic sync_line;
    int err_total = 0;
    int n_checks = 0;
    int ev_cnt = 0;
    int ev0 = 0;

    // Clock, input merge and event counting.
    always #5 clk_in = ~clk_in;
    assign opto = opto_tb | {28'h0, sync_line, 3'h0};
    always @(posedge clk_in) if (event_out === 1'h1) ev_cnt <= ev_cnt + 1;

    rtcs_top #(.N_IN(32), .CYC_PER_SEC(1000), .FILT_CYC(5), .SLEW_CYC(10)) i_rtcs_top (
        .clk_in(clk_in), .rstn_in(rstn_in), .opto_in(opto),
        .awaddr_in(awaddr_in), .awvalid_in(awvalid_in), .awready_out(awready_out),
        .wdata_in(wdata_in), .wstrb_in(wstrb_in), .wvalid_in(wvalid_in),
        .wready_out(wready_out), .bresp_out(bresp_out), .bvalid_out(bvalid_out),
        .bready_in(bready_in), .araddr_in(araddr_in), .arvalid_in(arvalid_in),
        .arready_out(arready_out), .rdata_out(rdata_out), .rresp_out(rresp_out),
        .rvalid_out(rvalid_out), .rready_in(rready_in), .irq_out(irq_out),
        .event_out(event_out), .sec_out(sec_out), .min_out(min_out), .hr_out(hr_out));

    rtcs_pulse_src i_rtcs_pulse_src (.clk_in(clk_in), .fire_in(fire), .len_in(plen),
        .line_out(sync_line));

    // Verdict and end of run.
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic hang;
        err_total++;
        $display("ERROR %0t ns: bus wait ran out", $time);
        complete_run();
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk_in);
    endtask

    // Write: both channels offered together, each dropped once taken, response awaited.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr_in <= a;
        wdata_in <= d;
        awvalid_in <= 1'h1;
        wvalid_in <= 1'h1;
        bready_in <= 1'h1;
        do begin
            @(posedge clk_in);
            n++;
            if (awready_out === 1'h1) awvalid_in <= 1'h0;
            if (wready_out === 1'h1) wvalid_in <= 1'h0;
            if (n > 200) hang();
        end while (bvalid_out !== 1'h1);
        bready_in <= 1'h0;
        chk(32'(bresp_out), 32'(er));
        // One edge passes so that a following call never raises bready in this time step.
        @(posedge clk_in);
    endtask

    // Read: data and response are taken at the edge where rvalid is seen.
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        araddr_in <= a;
        arvalid_in <= 1'h1;
        rready_in <= 1'h1;
        do begin
            @(posedge clk_in);
            n++;
            if (arready_out === 1'h1) arvalid_in <= 1'h0;
            if (n > 200) hang();
        end while (rvalid_out !== 1'h1);
        d = rdata_out;
        rs = rresp_out;
        rready_in <= 1'h0;
        // One edge passes so that a following call never raises rready in this time step.
        @(posedge clk_in);
    endtask

    function automatic logic [31:0] tw(input logic [5:0] m, input logic [5:0] s);
        return {11'h0, 5'h13, 2'h0, m, 2'h0, s};
    endfunction

    task automatic pulse(input logic [15:0] l);
        plen <= l;
        fire <= 1'h1;
        @(posedge clk_in);
        fire <= 1'h0;
    endtask

    // Sets the time to 19:47:s, pulses the input and checks the correction taken.
    task automatic sync_case(input logic [5:0] s);
        logic slew;
        logic [31:0] ex;
        slew = (s < 6'h03) || (s > 6'h38);
        ex = slew ? tw(6'h2F, s) : (s < 6'h1E) ? tw(6'h2F, 6'h00) : tw(6'h30, 6'h00);
        wr(8'h10, 32'h7, 2'h0);
        wr(8'h0C, tw(6'h2F, s), 2'h0);
        pulse(16'h0014);
        tick(30);
        chk({11'h0, hr_out, 2'h0, min_out, 2'h0, sec_out}, ex);
        rdr(8'h0C, rv);
        chk(rv, ex);
        rdr(8'h10, rv);
        chk(rv, slew ? 32'h2 : 32'h1);
        rdr(8'h18, rv);
        if (slew) chk(32'(rv[31]), 32'(s > 6'h38));
    endtask

    // Time write, optional pulse, then the seconds seen at the port.
    task automatic trial(input logic go, input logic [15:0] l, input logic [5:0] ex);
        wr(8'h0C, tw(6'h2F, 6'h0A), 2'h0);
        if (go) pulse(l);
        tick(30);
        chk(32'(sec_out), 32'(ex));
    endtask

    // Main sequence.
    initial begin
        tick(6);
        rstn_in <= 1'h1;
        tick(2);
        rdr(8'h00, rv);
        chk(rv, rtcs_pkg::CTRL_RST);
        rdr(8'h04, rv);
        chk(rv, rtcs_pkg::EVMASK_RST);
        rdr(8'h08, rv);
        chk(rv, rtcs_pkg::FILT_RST);
        wr(8'h1C, 32'h1, rtcs_pkg::RESP_SLVERR);
        rdr(8'h1C, rv);
        chk(rv, 32'h0);
        chk(32'(rs), 32'(rtcs_pkg::RESP_SLVERR));
        $display("test registers done");
        wr(8'h00, 32'h0000_0703, 2'h0);
        wr(8'h04, 32'hFFFF_FFF7, 2'h0);
        wr(8'h08, 32'hFFFF_FFF7, 2'h0);
        for (int i = 0; i < 6; i++) sync_case(CS[i]);
        chk(32'(irq_out), 32'h0);
        $display("test step and slew done");
        pulse(16'h0190);
        tick(30);
        trial(1'h0, 16'h0, 6'h0A);
        tick(400);
        trial(1'h1, 16'h0003, 6'h00);
        wr(8'h08, 32'hFFFF_FFFF, 2'h0);
        trial(1'h1, 16'h0003, 6'h0A);
        trial(1'h1, 16'h0014, 6'h00);
        wr(8'h00, 32'h0000_0303, 2'h0);
        trial(1'h1, 16'h0014, 6'h0A);
        chk(32'(ev_cnt), 32'h0);
        $display("test request path done");
        wr(8'h10, 32'h7, 2'h0);
        wr(8'h14, 32'h4, 2'h0);
        wr(8'h00, 32'h0000_0703, 2'h0);
        ev0 = ev_cnt;
        opto_tb[5] <= 1'h1;
        tick(4);
        chk(32'(ev_cnt - ev0), 32'h1);
        chk(32'(irq_out), 32'h1);
        wr(8'h10, 32'h4, 2'h0);
        tick(3);
        chk(32'(irq_out), 32'h0);
        wr(8'h00, 32'h0000_0603, 2'h0);
        opto_tb[5] <= 1'h0;
        tick(4);
        chk(32'(ev_cnt - ev0), 32'h1);
        $display("test events done");
        complete_run();
    end
endmodule

// File: src/rtcs_pkg.sv
package rtcs_pkg;
    // Clock rate and the time figures of the block.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MARGIN_S = 3;
    localparam int unsigned FILT_MS = 10;
    localparam int unsigned SLEW_MS = 10;
    localparam int unsigned PULSE_MS = 20;
    localparam int unsigned FILT_CYC = (CLK_HZ / MS_PER_S) * FILT_MS;
    localparam int unsigned SLEW_CYC = (CLK_HZ / MS_PER_S) * SLEW_MS;
    // Calendar limits.
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [5:0] MIN_LAST = 6'h3B;
    localparam logic [4:0] HR_LAST = 5'h17;
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;
    localparam logic [5:0] ROUND_UP_SEC = 6'h1E;
    // Register byte offsets.
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_EVMASK = 8'h04;
    localparam logic [7:0] OFF_FILT = 8'h08;
    localparam logic [7:0] OFF_TIME = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_IMASK = 8'h14;
    localparam logic [7:0] OFF_CORR = 8'h18;
    // Control register fields.
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 5;
    localparam int OPTO_EV_BIT = 8;
    localparam int PROT_EV_BIT = 9;
    localparam int SYNC_EN_BIT = 10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0700;
    localparam logic [31:0] EVMASK_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] FILT_RST = 32'hFFFF_FFFF;
    // Time register fields.
    localparam int SEC_LSB = 0;
    localparam int MIN_LSB = 8;
    localparam int HR_LSB = 16;
    // Status and mask bits.
    localparam int ST_STEP = 0;
    localparam int ST_SLEW = 1;
    localparam int ST_EVT = 2;
    localparam int ST_W = 3;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: src/rtcs_top.sv
// Summary of operation
// - A selectable digital input is routed to the internal time-sync request signal.
// - A step rounds to nearest minute: seconds 0-29 down, 30-59 up.
// - Within three seconds of the minute the clock slews instead of stepping.
// - A per-input event mask suppresses events while recording stays enabled.
// - A per-input filter bit; clearing it bypasses the 10 ms noise filter, which acts on the routed sync input only.
module rtcs_top #(
    parameter int N_IN = 32,
    parameter int CYC_PER_SEC = rtcs_pkg::CLK_HZ,
    parameter int FILT_CYC = rtcs_pkg::FILT_CYC,
    parameter int SLEW_CYC = rtcs_pkg::SLEW_CYC
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rstn_in,
    // Digital inputs.
    input wire logic [N_IN-1:0] opto_in,
    // AXI4-Lite write channels.
    input wire logic [rtcs_pkg::ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // AXI4-Lite read channels.
    input wire logic [rtcs_pkg::ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // Clock state and events.
    output logic irq_out,
    output logic event_out,
    output logic [5:0] sec_out,
    output logic [5:0] min_out,
    output logic [4:0] hr_out
);
    // Parameter values that the logic cannot serve are refused.
    if (N_IN < 1 || N_IN > 32 || FILT_CYC < 3 || SLEW_CYC < 1 || SLEW_CYC >= CYC_PER_SEC / 2) begin
        $error("rtcs_top: unsupported parameter values");
    end

    localparam logic [31:0] CPS = 32'(CYC_PER_SEC);
    localparam logic [31:0] FILT_LAST = 32'(FILT_CYC - 1);
    localparam logic [31:0] SLEW_MAX = 32'(SLEW_CYC);
    localparam logic [5:0] MARGIN = 6'(rtcs_pkg::MARGIN_S);

    // Merges written bytes into a register under the byte strobes.
    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Advances hours and minutes by one minute, wrapping at midnight.
    function automatic logic [10:0] inc_min(input logic [4:0] hr, input logic [5:0] mn);
        logic [10:0] r;
        r = {hr, mn + 6'h01};
        if (mn >= rtcs_pkg::MIN_LAST) begin
            r[5:0] = 6'h00;
            r[10:6] = (hr >= rtcs_pkg::HR_LAST) ? 5'h00 : hr + 5'h01;
        end
        return r;
    endfunction

    logic [31:0] ctrl_reg, evmask_reg, filt_reg, imask_reg;
    logic [rtcs_pkg::ST_W-1:0] stat_reg;
    logic aw_hold_reg, w_hold_reg;
    logic [rtcs_pkg::ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [31:0] sub_reg, corr_reg, filt_cnt_reg;
    logic corr_fast_reg, raw_q_reg, filt_state_reg, level_prev_reg, sync_pulse_reg;
    logic [N_IN-1:0] opto_prev_reg;
    logic [rtcs_pkg::SEL_W-1:0] sel;
    logic opto_en, prot_en, sync_en, filt_on, sync_level, in_margin, wr_do, ar_take, evt_hit;
    logic aw_hold_next, w_hold_next, bvalid_next, rvalid_next;
    logic [31:0] step_cyc, sec_len, ahead_cyc, behind_cyc, rd_mux, wr_val;
    logic tick, rd_ok, wr_ok;
    logic [rtcs_pkg::ST_W-1:0] stat_set;

    // Control fields.
    assign sel = ctrl_reg[rtcs_pkg::SEL_LSB +: rtcs_pkg::SEL_W];
    assign opto_en = ctrl_reg[rtcs_pkg::OPTO_EV_BIT];
    assign prot_en = ctrl_reg[rtcs_pkg::PROT_EV_BIT];
    assign sync_en = ctrl_reg[rtcs_pkg::SYNC_EN_BIT];
    assign filt_on = (32'(sel) < 32'(N_IN)) ? filt_reg[sel] : 1'b0;

    // Bus handshakes: address and data are taken in either order.
    assign wr_do = aw_hold_reg && w_hold_reg && !bvalid_out;
    assign aw_hold_next = (aw_hold_reg || (awvalid_in && awready_out)) && !wr_do;
    assign w_hold_next = (w_hold_reg || (wvalid_in && wready_out)) && !wr_do;
    assign bvalid_next = wr_do || (bvalid_out && !bready_in);
    assign ar_take = arvalid_in && arready_out;
    assign rvalid_next = ar_take || (rvalid_out && !rready_in);
    assign wr_val = apply_strb(32'h0000_0000, wdata_reg, wstrb_reg);

    // Write-side channel state.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awready_out <= 1'b0;
            wready_out <= 1'b0;
            bvalid_out <= 1'b0;
            bresp_out <= rtcs_pkg::RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awready_out <= !aw_hold_next && !bvalid_next;
            wready_out <= !w_hold_next && !bvalid_next;
            bvalid_out <= bvalid_next;
            if (awvalid_in && awready_out) begin
                awaddr_reg <= awaddr_in;
            end
            if (wvalid_in && wready_out) begin
                wdata_reg <= wdata_in;
                wstrb_reg <= wstrb_in;
            end
            if (wr_do) begin
                bresp_out <= wr_ok ? rtcs_pkg::RESP_OKAY : rtcs_pkg::RESP_SLVERR;
            end
        end
    end

    // Write decode: which offsets exist.
    always_comb begin
        unique case (awaddr_reg)
            rtcs_pkg::OFF_CTRL, rtcs_pkg::OFF_EVMASK, rtcs_pkg::OFF_FILT, rtcs_pkg::OFF_TIME,
            rtcs_pkg::OFF_STAT, rtcs_pkg::OFF_IMASK, rtcs_pkg::OFF_CORR: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // Software-written configuration registers.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ctrl_reg <= rtcs_pkg::CTRL_RST;
            evmask_reg <= rtcs_pkg::EVMASK_RST;
            filt_reg <= rtcs_pkg::FILT_RST;
            imask_reg <= 32'h0000_0000;
        end else if (wr_do) begin
            if (awaddr_reg == rtcs_pkg::OFF_CTRL) begin
                ctrl_reg <= apply_strb(ctrl_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == rtcs_pkg::OFF_EVMASK) begin
                evmask_reg <= apply_strb(evmask_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == rtcs_pkg::OFF_FILT) begin
                filt_reg <= apply_strb(filt_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == rtcs_pkg::OFF_IMASK) begin
                imask_reg <= apply_strb(imask_reg, wdata_reg, wstrb_reg);
            end
        end
    end

    // Read data selection.
    always_comb begin
        rd_ok = 1'b1;
        unique case (araddr_in)
            rtcs_pkg::OFF_CTRL: rd_mux = ctrl_reg;
            rtcs_pkg::OFF_EVMASK: rd_mux = evmask_reg;
            rtcs_pkg::OFF_FILT: rd_mux = filt_reg;
            rtcs_pkg::OFF_TIME: rd_mux = {11'h000, hr_out, 2'h0, min_out, 2'h0, sec_out};
            rtcs_pkg::OFF_STAT: rd_mux = 32'(stat_reg);
            rtcs_pkg::OFF_IMASK: rd_mux = imask_reg;
            rtcs_pkg::OFF_CORR: rd_mux = {corr_fast_reg, corr_reg[30:0]};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Read channel: data answers one cycle after the address is taken.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            arready_out <= 1'b0;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            rresp_out <= rtcs_pkg::RESP_OKAY;
        end else begin
            arready_out <= !rvalid_next;
            rvalid_out <= rvalid_next;
            if (ar_take) begin
                rdata_out <= rd_mux;
                rresp_out <= rd_ok ? rtcs_pkg::RESP_OKAY : rtcs_pkg::RESP_SLVERR;
            end
        end
    end

    // Routed input, optional noise filter and rising-edge request.
    assign sync_level = filt_on ? filt_state_reg : raw_q_reg;
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            raw_q_reg <= 1'b0;
            filt_state_reg <= 1'b0;
            filt_cnt_reg <= 32'h0000_0000;
            level_prev_reg <= 1'b0;
            sync_pulse_reg <= 1'b0;
        end else begin
            raw_q_reg <= (32'(sel) < 32'(N_IN)) ? opto_in[sel] : 1'b0;
            if (raw_q_reg == filt_state_reg) begin
                filt_cnt_reg <= 32'h0000_0000;
            end else if (filt_cnt_reg >= FILT_LAST) begin
                filt_state_reg <= raw_q_reg;
                filt_cnt_reg <= 32'h0000_0000;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + 32'h0000_0001;
            end
            level_prev_reg <= sync_level;
            sync_pulse_reg <= sync_en && sync_level && !level_prev_reg;
        end
    end

    // Slewed second length and distance to the nearest minute.
    assign step_cyc = (corr_reg < SLEW_MAX) ? corr_reg : SLEW_MAX;
    assign sec_len = corr_fast_reg ? CPS - step_cyc : CPS + step_cyc;
    assign tick = sub_reg >= sec_len - 32'h0000_0001;
    assign ahead_cyc = 32'(sec_out) * CPS + sub_reg;
    assign behind_cyc = 32'(rtcs_pkg::SEC_PER_MIN - sec_out) * CPS - sub_reg;
    assign in_margin = (sec_out < MARGIN) || (sec_out >= rtcs_pkg::SEC_PER_MIN - MARGIN);

    // Timekeeping with step and slew correction.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sub_reg <= 32'h0000_0000;
            sec_out <= 6'h00;
            min_out <= 6'h00;
            hr_out <= 5'h00;
            corr_reg <= 32'h0000_0000;
            corr_fast_reg <= 1'b0;
        end else begin
            if (tick) begin
                sub_reg <= 32'h0000_0000;
                corr_reg <= corr_reg - step_cyc;
                if (sec_out >= rtcs_pkg::SEC_LAST) begin
                    sec_out <= 6'h00;
                    {hr_out, min_out} <= inc_min(hr_out, min_out);
                end else begin
                    sec_out <= sec_out + 6'h01;
                end
            end else begin
                sub_reg <= sub_reg + 32'h0000_0001;
            end
            if (wr_do && awaddr_reg == rtcs_pkg::OFF_TIME) begin
                sub_reg <= 32'h0000_0000;
                sec_out <= wr_val[rtcs_pkg::SEC_LSB +: 6];
                min_out <= wr_val[rtcs_pkg::MIN_LSB +: 6];
                hr_out <= wr_val[rtcs_pkg::HR_LSB +: 5];
                corr_reg <= 32'h0000_0000;
            end
            if (sync_pulse_reg) begin
                if (in_margin) begin
                    corr_fast_reg <= sec_out >= MARGIN;
                    corr_reg <= (sec_out < MARGIN) ? ahead_cyc : behind_cyc;
                end else begin
                    sub_reg <= 32'h0000_0000;
                    sec_out <= 6'h00;
                    corr_reg <= 32'h0000_0000;
                    {hr_out, min_out} <= (sec_out >= rtcs_pkg::ROUND_UP_SEC) ?
                        inc_min(hr_out, min_out) : {hr_out, min_out};
                end
            end
        end
    end

    // Input events gated by the per-input mask and the recording enables.
    assign evt_hit = opto_en && prot_en &&
                     (|((opto_in ^ opto_prev_reg) & evmask_reg[N_IN-1:0]));
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            opto_prev_reg <= '0;
            event_out <= 1'b0;
        end else begin
            opto_prev_reg <= opto_in;
            event_out <= evt_hit;
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear.
    assign stat_set = {evt_hit, sync_pulse_reg && in_margin, sync_pulse_reg && !in_margin};
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            stat_reg <= '0;
            irq_out <= 1'b0;
        end else begin
            if (wr_do && awaddr_reg == rtcs_pkg::OFF_STAT) begin
                stat_reg <= (stat_reg & ~wr_val[rtcs_pkg::ST_W-1:0]) | stat_set;
            end else begin
                stat_reg <= stat_reg | stat_set;
            end
            irq_out <= |(stat_reg & imask_reg[rtcs_pkg::ST_W-1:0]);
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_step_req;
        sync_pulse_reg && !in_margin;
    endsequence
    sequence s_slew_req;
        sync_pulse_reg && in_margin;
    endsequence

    property p_route;
        (sync_en && !filt_on && raw_q_reg && !level_prev_reg) |=> sync_pulse_reg;
    endproperty
    a_route: assert property (p_route) else $error("routed input edge gave no request");

    property p_round_down;
        (s_step_req and (sec_out < rtcs_pkg::ROUND_UP_SEC))
            |=> (sec_out == 6'h00 && sub_reg == 32'h0000_0000 && min_out == $past(min_out));
    endproperty
    a_round_down: assert property (p_round_down) else $error("round down step wrong");

    property p_round_up;
        (s_step_req and (sec_out >= rtcs_pkg::ROUND_UP_SEC))
            |=> (sec_out == 6'h00 && {hr_out, min_out} == inc_min($past(hr_out), $past(min_out)));
    endproperty
    a_round_up: assert property (p_round_up) else $error("round up step wrong");

    // A second that rolls over in the same cycle may still carry the minute forward.
    property p_slew;
        s_slew_req |=> (corr_reg == ($past(sec_out) < MARGIN ?
            $past(ahead_cyc) : $past(behind_cyc)) &&
            {hr_out, min_out} == ($past(tick && sec_out >= rtcs_pkg::SEC_LAST) ?
            inc_min($past(hr_out), $past(min_out)) : {$past(hr_out), $past(min_out)}));
    endproperty
    a_slew: assert property (p_slew) else $error("slew request stepped the clock");

    property p_mask;
        event_out |-> $past(opto_en && prot_en &&
            ((opto_in ^ opto_prev_reg) & evmask_reg[N_IN-1:0]) != '0);
    endproperty
    a_mask: assert property (p_mask) else $error("masked input produced an event");

    property p_filter;
        ($rose(raw_q_reg) && filt_on && !filt_state_reg && !sync_pulse_reg) |=>
            (!filt_state_reg)[*2];
    endproperty
    a_filter: assert property (p_filter) else $error("filter passed a short change");

    property p_one_shot;
        sync_pulse_reg |=> !sync_pulse_reg;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("request lasted two cycles");
endmodule
